// ==== tb_uart_loopback_aux_output_ctrl.sv ====
// self-checking bench for the loopback and aux output two control
// assumes ulaoc_pkg, ulaoc_ctrl and ulaoc_modem are compiled first
module tb_uart_loopback_aux_output_ctrl import ulaoc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset_n, reg_write, reg_read, tx_shift_out, rx_shift_in, baud, dma, mie;
    logic rx_irq_in, tx_irq_in, modem_irq, rx_irq, tx_irq, serial_tx_pin, serial_rx_pin;
    logic cts_n_pin, dsr_n_pin, ri_n_pin, dcd_n_pin, dtr_n_pin, rts_n_pin, shared_out_pin;
    logic loopback_active, rx_level, rd_d, b;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic [3:0] stat_lv, v, lv;
    logic [15:0] e;
    logic [7:0] pv;
    assign pv = {3'h0, loopback_active, serial_tx_pin, dtr_n_pin, rts_n_pin, shared_out_pin};
    logic [15:0] exp_q[$];
    int err_count, n_checks, cyc, i, k;

    ulaoc_ctrl DUT (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .tx_shift_out(tx_shift_out), .rx_shift_in(rx_shift_in), .baud_clock_output(baud),
        .receive_dma_request(dma), .modem_irq_enable(mie), .rx_irq_in(rx_irq_in),
        .tx_irq_in(tx_irq_in), .modem_irq(modem_irq), .rx_irq(rx_irq), .tx_irq(tx_irq),
        .serial_tx_pin(serial_tx_pin), .serial_rx_pin(serial_rx_pin), .cts_n_pin(cts_n_pin),
        .dsr_n_pin(dsr_n_pin), .ri_n_pin(ri_n_pin), .dcd_n_pin(dcd_n_pin),
        .dtr_n_pin(dtr_n_pin), .rts_n_pin(rts_n_pin), .shared_out_pin(shared_out_pin),
        .loopback_active(loopback_active));
    ulaoc_modem modem (.clk(clk), .rx_level(rx_level), .stat_lv(stat_lv),
        .serial_rx_pin(serial_rx_pin), .cts_n_pin(cts_n_pin), .dsr_n_pin(dsr_n_pin),
        .ri_n_pin(ri_n_pin), .dcd_n_pin(dcd_n_pin));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one write or one read; a read notes its expected data and mask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
        input logic [7:0] m);
        @(posedge clk);
        reg_write <= wr;
        reg_read <= !wr;
        reg_addr <= a;
        reg_wdata <= d;
        if (!wr) exp_q.push_back({m, d});
        @(posedge clk);
        reg_write <= 1'b0;
        reg_read <= 1'b0;
    endtask

    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // read data stand in the cycle after the strobe
    always @(posedge clk) begin
        if (rd_d) begin
            e = exp_q.pop_front();
            chk("reg_rdata", e[7:0] & e[15:8], reg_rdata & e[15:8]);
        end
        rd_d <= reg_read;
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            print_verdict();
        end
    end

    initial begin
        {reset_n, reg_write, reg_read, tx_shift_out, baud, dma, mie, rd_d} = '0;
        {rx_irq_in, tx_irq_in, reg_addr, reg_wdata, stat_lv} = '0;
        rx_level = 1'b1;
        void'($urandom(32'h82e39916));
        repeat (8) @(posedge clk);
        #1;
        chk("reset pins", 8'h0F, pv);
        chk("loopback_active", 8'h00, {7'h0, loopback_active});
        @(posedge clk);
        reset_n <= 1'b1;
        bus(0, MLC_OFFSET, MLC_RESET, 8'hFF);
        bus(0, PFS_OFFSET, {6'h0, PFS_RESET}, 8'hFF);
        $display("test reset done");
        for (i = 0; i < 16; i++) begin
            v = i[3:0];
            bus(1, MLC_OFFSET, {4'h0, v}, 8'h00);
            settle();
            chk("ctrl pins", {5'h0, ~v[0], ~v[1], ~v[3]}, pv & 8'h07);
        end
        bus(1, 4'hF, 8'hFF, 8'h00);
        bus(0, 4'hF, 8'h00, 8'hFF);
        bus(0, MLC_OFFSET, 8'h0F, 8'hFF);
        $display("test aux two done");
        for (i = 0; i < 4; i++) begin
            bus(1, PFS_OFFSET, {6'h0, i[1:0]}, 8'h00);
            for (k = 0; k < 4; k++) begin
                @(posedge clk);
                baud <= k[0];
                dma <= k[1];
                settle();
                b = i == 1 ? k[0] : i == 2 ? k[1] : 1'b0;
                chk("shared_out_pin", {7'h0, b}, pv & 8'h01);
            end
        end
        bus(1, PFS_OFFSET, 8'h00, 8'h00);
        $display("test pin select done");
        for (i = 0; i < 16; i++) begin
            v = 4'($urandom());
            lv = 4'($urandom());
            b = 1'($urandom());
            bus(1, MLC_OFFSET, {3'h0, i[3], v}, 8'h00);
            @(posedge clk);
            tx_shift_out <= b;
            rx_level <= ~b;
            stat_lv <= lv;
            settle();
            chk("loopback_active", {7'h0, i[3]}, {7'h0, loopback_active});
            chk("serial_tx_pin", {7'h0, i[3] | b}, {7'h0, serial_tx_pin});
            chk("rx_shift_in", {7'h0, i[3] ~^ b}, {7'h0, rx_shift_in});
            if (i[3]) chk("loop pins", 8'h07, pv & 8'h07);
            if (i[3]) bus(0, MSR_OFFSET, {v[3], v[2], v[0], v[1], 4'h0}, 8'hF0);
            else bus(0, MSR_OFFSET, {lv, 4'h0}, 8'hF0);
        end
        $display("test loopback done");
        @(posedge clk);
        mie <= 1'b1;
        bus(1, MLC_OFFSET, 8'h10, 8'h00);
        settle();
        bus(0, MSR_OFFSET, 8'h00, 8'h00);
        settle();
        chk("modem_irq idle", 8'h00, {7'h0, modem_irq});
        bus(1, MLC_OFFSET, 8'h12, 8'h00);
        settle();
        chk("modem_irq set", 8'h01, {7'h0, modem_irq});
        bus(0, MSR_OFFSET, 8'h11, 8'hFF);
        settle();
        chk("modem_irq cleared", 8'h00, {7'h0, modem_irq});
        @(posedge clk);
        mie <= 1'b0;
        bus(1, MLC_OFFSET, 8'h10, 8'h00);
        settle();
        chk("modem_irq gated", 8'h00, {7'h0, modem_irq});
        for (i = 0; i < 4; i++) begin
            @(posedge clk);
            rx_irq_in <= i[0];
            tx_irq_in <= i[1];
            #1;
            chk("rx tx irq", {6'h0, i[1:0]}, {6'h0, tx_irq, rx_irq});
        end
        $display("test interrupts done");
        bus(1, PFS_OFFSET, 8'h01, 8'h00);
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk("mid reset pins", 8'h0F, pv);
        chk("modem_irq reset", 8'h00, {7'h0, modem_irq});
        @(posedge clk);
        reset_n <= 1'b1;
        bus(0, MLC_OFFSET, MLC_RESET, 8'hFF);
        bus(0, PFS_OFFSET, {6'h0, PFS_RESET}, 8'hFF);
        $display("test mid reset done");
        settle();
        chk("read queue", 8'h00, 8'(exp_q.size()));
        print_verdict();
    end
endmodule

// ==== ulaoc_ctrl.sv ====
// loopback and auxiliary output two control for one serial channel
// assumes the transmitter, receiver and interrupt logic of the channel sit around it

module ulaoc_ctrl
    import ulaoc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,

    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [DATA_W-1:0] reg_rdata,

    // channel data path
    input wire logic tx_shift_out,
    output logic rx_shift_in,

    // channel internal signals for the shared pin and interrupts
    input wire logic baud_clock_output,
    input wire logic receive_dma_request,
    input wire logic modem_irq_enable,
    input wire logic rx_irq_in,
    input wire logic tx_irq_in,
    output logic modem_irq,
    output logic rx_irq,
    output logic tx_irq,

    // serial pins
    output logic serial_tx_pin,
    input wire logic serial_rx_pin,

    // modem status pins, active low
    input wire logic cts_n_pin,
    input wire logic dsr_n_pin,
    input wire logic ri_n_pin,
    input wire logic dcd_n_pin,

    // modem control pins, active low
    output logic dtr_n_pin,
    output logic rts_n_pin,
    output logic shared_out_pin,

    // state seen by the rest of the channel
    output logic loopback_active
);

    logic [7:0] mlc_q;
    logic [PFS_W-1:0] pfs_q;
    logic [3:0] stat_now;
    logic [3:0] stat_q;
    logic [3:0] delta_q;
    logic [3:0] delta_set;
    logic msr_rd;
    logic loop_on;
    logic aux_two_level;
    logic shared_d;

    assign loop_on = mlc_q[MLC_LOOP_BIT];
    assign loopback_active = loop_on;
    assign msr_rd = reg_read && (reg_addr == MSR_OFFSET);

    // control register writes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mlc_q <= MLC_RESET;
        end else if (reg_write && reg_addr == MLC_OFFSET) begin
            mlc_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pfs_q <= PFS_RESET;
        end else if (reg_write && reg_addr == PFS_OFFSET) begin
            pfs_q <= reg_wdata[PFS_W-1:0];
        end
    end

    // live modem status, order cts, dsr, ri, dcd
    always_comb begin
        if (loop_on) begin
            stat_now[0] = mlc_q[MLC_RTS_BIT];
            stat_now[1] = mlc_q[MLC_DTR_BIT];
            stat_now[2] = mlc_q[MLC_AUX1_BIT];
            stat_now[3] = mlc_q[MLC_AUX2_BIT];
        end else begin
            stat_now[0] = ~cts_n_pin;
            stat_now[1] = ~dsr_n_pin;
            stat_now[2] = ~ri_n_pin;
            stat_now[3] = ~dcd_n_pin;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stat_q <= MSR_DELTA_RESET;
        end else begin
            stat_q <= stat_now;
        end
    end

    // change detection, ring indicator reports its trailing edge only
    always_comb begin
        delta_set[0] = stat_now[0] ^ stat_q[0];
        delta_set[1] = stat_now[1] ^ stat_q[1];
        delta_set[2] = stat_q[2] & ~stat_now[2];
        delta_set[3] = stat_now[3] ^ stat_q[3];
    end

    // sticky deltas cleared by a status read; a new change wins over the clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            delta_q <= MSR_DELTA_RESET;
        end else if (msr_rd) begin
            delta_q <= delta_set;
        end else begin
            delta_q <= delta_q | delta_set;
        end
    end

    assign modem_irq = modem_irq_enable && (delta_q != MSR_DELTA_RESET);

    // receive and transmit interrupts are not gated by loopback
    assign rx_irq = rx_irq_in;
    assign tx_irq = tx_irq_in;

    // read data stand in the cycle after the strobe
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            unique case (reg_addr)
                MLC_OFFSET: reg_rdata <= mlc_q;
                PFS_OFFSET: reg_rdata <= {6'h00, pfs_q};
                MSR_OFFSET: reg_rdata <= {stat_now[3], stat_now[2], stat_now[1], stat_now[0],
                    delta_q};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // serial pins and internal loop
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            serial_tx_pin <= 1'b1;
        end else begin
            serial_tx_pin <= loop_on ? 1'b1 : tx_shift_out;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_shift_in <= 1'b1;
        end else if (loop_on) begin
            rx_shift_in <= tx_shift_out;
        end else begin
            rx_shift_in <= serial_rx_pin;
        end
    end

    // modem control pins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dtr_n_pin <= 1'b1;
            rts_n_pin <= 1'b1;
        end else begin
            dtr_n_pin <= loop_on | ~mlc_q[MLC_DTR_BIT];
            rts_n_pin <= loop_on | ~mlc_q[MLC_RTS_BIT];
        end
    end

    // shared output pin
    assign aux_two_level = loop_on | ~mlc_q[MLC_AUX2_BIT];

    always_comb begin
        unique case (pfs_q)
            PFS_BAUD_CLK: shared_d = baud_clock_output;
            PFS_RX_DMA: shared_d = receive_dma_request;
            default: shared_d = aux_two_level;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            shared_out_pin <= 1'b1;
        end else begin
            shared_out_pin <= shared_d;
        end
    end

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_loop_bit_write: assert property (
        reg_write && reg_addr == MLC_OFFSET |=> loop_on == $past(reg_wdata[MLC_LOOP_BIT]))
        else $error("loopback bit did not follow write");

    a_tx_pin_mark: assert property (
        loop_on |=> serial_tx_pin)
        else $error("transmit pin left marking state in loopback");

    a_tx_pin_normal: assert property (
        !loop_on |=> serial_tx_pin == $past(tx_shift_out))
        else $error("transmit pin not following shift output");

    a_rx_ignore: assert property (
        loop_on && !serial_rx_pin && tx_shift_out |=> rx_shift_in)
        else $error("receive pin reached receiver in loopback");

    a_rx_loop_path: assert property (
        loop_on |=> rx_shift_in == $past(tx_shift_out))
        else $error("transmit output not looped into receiver");

    a_status_ignore: assert property (
        loop_on && $stable(mlc_q) ##1 loop_on && $stable(mlc_q) |-> delta_set == 4'h0)
        else $error("modem pin change seen in loopback");

    a_status_route: assert property (
        loop_on |-> stat_now == {mlc_q[MLC_AUX2_BIT], mlc_q[MLC_AUX1_BIT],
            mlc_q[MLC_DTR_BIT], mlc_q[MLC_RTS_BIT]})
        else $error("control outputs not routed to status inputs");

    a_pins_inactive: assert property (
        loop_on [*2] |-> dtr_n_pin && rts_n_pin)
        else $error("modem control pin active in loopback");

    a_aux_two_pin: assert property (
        pfs_q == PFS_AUX_TWO && $stable(pfs_q) && !loop_on
        |=> shared_out_pin == !$past(mlc_q[MLC_AUX2_BIT]))
        else $error("aux output two not inverted from control bit");

    a_pin_select: assert property (
        pfs_q == PFS_BAUD_CLK |=> shared_out_pin == $past(baud_clock_output))
        else $error("shared pin not carrying baud clock");

    a_reset_select: assert property (
        $rose(reset_n) |-> pfs_q == PFS_AUX_TWO && shared_out_pin)
        else $error("shared pin not on aux output two after reset");

    a_ring_from_aux: assert property (
        reg_read && reg_addr == MSR_OFFSET && loop_on
        |=> reg_rdata[MSR_RI_BIT] == $past(mlc_q[MLC_AUX1_BIT]))
        else $error("ring status not taken from aux output one");

    a_modem_irq: assert property (
        $past(loop_on) && loop_on && modem_irq_enable && !msr_rd && $changed(mlc_q[MLC_RTS_BIT])
        |=> modem_irq)
        else $error("loopback control change raised no modem interrupt");

    a_irq_gated: assert property (
        !modem_irq_enable |-> !modem_irq)
        else $error("modem interrupt not gated by enable");

    a_mlc_hold: assert property (
        !(reg_write && reg_addr == MLC_OFFSET) |=> $stable(mlc_q))
        else $error("control register changed without a write");

    a_mlc_readback: assert property (
        reg_read && reg_addr == MLC_OFFSET |=> reg_rdata == $past(mlc_q))
        else $error("control register read back wrong");

    a_unmapped_read: assert property (
        reg_read && reg_addr != MLC_OFFSET && reg_addr != PFS_OFFSET && reg_addr != MSR_OFFSET
        |=> reg_rdata == 8'h00)
        else $error("unmapped address read gave nonzero data");

    a_pfs_hold: assert property (
        !(reg_write && reg_addr == PFS_OFFSET) |=> $stable(pfs_q))
        else $error("pin select changed without a write");

    a_pfs_write: assert property (
        reg_write && reg_addr == PFS_OFFSET |=> pfs_q == $past(reg_wdata[PFS_W-1:0]))
        else $error("pin select did not follow write");

    a_pfs_readback: assert property (
        reg_read && reg_addr == PFS_OFFSET |=> reg_rdata == {6'h00, $past(pfs_q)})
        else $error("pin select read back wrong");

    a_dma_select: assert property (
        pfs_q == PFS_RX_DMA |=> shared_out_pin == $past(receive_dma_request))
        else $error("shared pin not carrying receive DMA request");

    a_code3_aux: assert property (
        pfs_q == 2'h3 && !loop_on |=> shared_out_pin == !$past(mlc_q[MLC_AUX2_BIT]))
        else $error("spare select code not acting as aux output two");

    a_aux_two_loop: assert property (
        pfs_q == PFS_AUX_TWO && loop_on |=> shared_out_pin)
        else $error("aux output two active in loopback");

    a_dtr_normal: assert property (
        !loop_on |=> dtr_n_pin == !$past(mlc_q[MLC_DTR_BIT]))
        else $error("terminal ready pin not following control bit");

    a_rts_normal: assert property (
        !loop_on |=> rts_n_pin == !$past(mlc_q[MLC_RTS_BIT]))
        else $error("request to send pin not following control bit");

    a_rx_normal: assert property (
        !loop_on |=> rx_shift_in == $past(serial_rx_pin))
        else $error("receive pin not reaching receiver in normal mode");

    a_status_normal: assert property (
        !loop_on |-> stat_now == ~{dcd_n_pin, ri_n_pin, dsr_n_pin, cts_n_pin})
        else $error("status inputs not following modem pins");

    a_dsr_route: assert property (
        $past(loop_on) && loop_on && $changed(mlc_q[MLC_DTR_BIT]) |=> delta_q[MSR_DDSR_BIT])
        else $error("terminal ready change not seen as set ready change");

    a_dcd_route: assert property (
        $past(loop_on) && loop_on && $changed(mlc_q[MLC_AUX2_BIT]) |=> delta_q[MSR_DDCD_BIT])
        else $error("aux output two change not seen as carrier change");

    a_ri_route: assert property (
        $past(loop_on) && loop_on && $fell(mlc_q[MLC_AUX1_BIT]) |=> delta_q[MSR_TERI_BIT])
        else $error("aux output one fall not seen as ring trailing edge");

    a_msr_live: assert property (
        msr_rd |=> reg_rdata[7:4] == $past(stat_now))
        else $error("status read gave wrong live levels");

    a_msr_delta: assert property (
        msr_rd |=> reg_rdata[3:0] == $past(delta_q))
        else $error("status read gave wrong change bits");

    a_delta_clear: assert property (
        msr_rd && delta_set == MSR_DELTA_RESET |=> delta_q == MSR_DELTA_RESET)
        else $error("status read did not clear change bits");

    a_delta_sticky: assert property (
        !msr_rd |=> (delta_q & $past(delta_q)) == $past(delta_q))
        else $error("change bit lost without a status read");

    a_delta_capture: assert property (
        delta_set != MSR_DELTA_RESET |=> (delta_q & $past(delta_set)) == $past(delta_set))
        else $error("status change not captured");

    a_ri_leading: assert property (
        !stat_q[2] && stat_now[2] && !delta_q[2] |=> !delta_q[MSR_TERI_BIT])
        else $error("ring leading edge set a change bit");

    a_irq_set: assert property (
        modem_irq_enable && delta_q != MSR_DELTA_RESET |-> modem_irq)
        else $error("pending change raised no modem interrupt");

    a_irq_pass: assert property (
        rx_irq == rx_irq_in && tx_irq == tx_irq_in)
        else $error("receive or transmit interrupt not passed through");

endmodule

// ==== ulaoc_modem.sv ====
// modem model driving the serial receive pin and the four status pins
// assumes the bench sets the wanted levels; pins change on the clock edge
module ulaoc_modem (
    // clock
    input wire logic clk,
    // wanted levels: line, then dcd ri dsr cts active high
    input wire logic rx_level,
    input wire logic [3:0] stat_lv,
    // pins toward the channel
    output logic serial_rx_pin,
    output logic cts_n_pin,
    output logic dsr_n_pin,
    output logic ri_n_pin,
    output logic dcd_n_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge clk) begin
        serial_rx_pin <= rx_level;
        cts_n_pin <= ~stat_lv[0];
        dsr_n_pin <= ~stat_lv[1];
        ri_n_pin <= ~stat_lv[2];
        dcd_n_pin <= ~stat_lv[3];
    end
endmodule

// ==== ulaoc_pkg.sv ====
// constants for the loopback and auxiliary output two control of one channel
// assumes one 100 MHz clock shared with the rest of the channel
//
// Summary of operation
// - modem_line_control bit 4 enables internal loopback, read/write, reset 0.
// - in loopback the serial transmit pin idles at marking level, logic 1.
// - in loopback the external serial receive pin is ignored.
// - in loopback the transmit shift output feeds the receive shift input.
// - in loopback the four external modem status pins are ignored.
// - in loopback DTR, RTS, aux one and aux two drive the status inputs.
// - in loopback DTR, RTS and aux output two sit inactive high; a shared pin set to baud clock or DMA keeps carrying it.
// - in loopback each transmitted character is received at once by this channel.
// - in loopback receive and transmit interrupts keep working from internal activity.
// - in loopback modem status interrupts come from control bits 3:0, still enabled-gated.
// - control bit 3 drives aux output two inverted; reset 0 gives logic 1.
// - aux output two shares a pin with baud clock and receive DMA, chosen by select.
// - after reset the shared pin carries aux output two.
// - in loopback aux output one sets ring indicator status bit 6.
package ulaoc_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [3:0] PFS_OFFSET = 4'h2;
    localparam logic [3:0] MLC_OFFSET = 4'h4;
    localparam logic [3:0] MSR_OFFSET = 4'h6;

    // modem_line_control fields
    localparam int MLC_DTR_BIT = 0;
    localparam int MLC_RTS_BIT = 1;
    localparam int MLC_AUX1_BIT = 2;
    localparam int MLC_AUX2_BIT = 3;
    localparam int MLC_LOOP_BIT = 4;
    localparam logic [7:0] MLC_RESET = 8'h00;

    // modem_status_register fields: deltas in 3:0, live levels in 7:4
    localparam int MSR_DCTS_BIT = 0;
    localparam int MSR_DDSR_BIT = 1;
    localparam int MSR_TERI_BIT = 2;
    localparam int MSR_DDCD_BIT = 3;
    localparam int MSR_CTS_BIT = 4;
    localparam int MSR_DSR_BIT = 5;
    localparam int MSR_RI_BIT = 6;
    localparam int MSR_DCD_BIT = 7;
    localparam logic [3:0] MSR_DELTA_RESET = 4'h0;

    // pin_function_select
    localparam int PFS_W = 2;
    typedef enum logic [PFS_W-1:0] {
        PFS_AUX_TWO = 2'h0,
        PFS_BAUD_CLK = 2'h1,
        PFS_RX_DMA = 2'h2
    } ulaoc_pin_fn_e;
    localparam logic [PFS_W-1:0] PFS_RESET = 2'h0;

endpackage
